// ### hdl/aom_crc16.sv
// Byte-wide 16-bit CRC accumulator with preload and clear
`timescale 1ns/1ps
module aom_crc16 import aom_pkg::*; #(
    parameter logic [15:0] POLY = CRC_POLY
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Control
    input wire logic init_i,
    input wire logic [15:0] init_val_i,
    input wire logic upd_i,
    input wire logic [7:0] byte_i,
    // Result
    output logic [15:0] crc_o
);
    // Bit 0 of the byte enters first, matching the serial order on the line
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r = r >> 1;
            if (fb) r = r ^ POLY;
        end
        crc_byte = r;
    endfunction

    wire [15:0] base = init_i ? init_val_i : crc_o;
    wire [15:0] next_crc = upd_i ? crc_byte(base, byte_i) : base;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) crc_o <= CRC_CLEAR;
        else crc_o <= next_crc;
    end
endmodule

// ### hdl/aom_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
module aom_fifo import aom_pkg::*; #(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL = (PTR_W+1)'(DEPTH);

    function automatic logic [PTR_W-1:0] inc_ptr(input logic [PTR_W-1:0] p);
        inc_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (count != FULL);
    assign out_valid_o = (count != '0);
    assign out_data_o = store[rd_ptr];

    always_ff @(posedge clock_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= inc_ptr(wr_ptr);
            if (pop) rd_ptr <= inc_ptr(rd_ptr);
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end
endmodule

// ### hdl/aom_mem_top.sv
// Memory functions of the add-only memory: command decode, storage, CRC, serial streaming
// Function
// - Data memory is 256 pages of 32 bytes, byte addressed by 16-bit start address.
// - Write byte goes to 8-bit scratchpad; device returns 16-bit CRC before programming.
// - Separate 2816-bit status memory, reached only by status commands.
// - Status bytes 000-01F: programmed page bit blocks data programming of that page.
// - Status bytes 020-03F: programmed bit blocks programming of that redirection byte.
// - Status bytes 040-05F are stored and returned, never steer hardware.
// - Status bytes 100-1FF are redirection bytes, stored and returned only.
// - Status 060-0FF and from 200 up read FF and ignore writes.
// - Programming only clears bits from one to zero.
// - Each function is command byte, then low address byte, then high address byte.
// - Writes go one byte at a time, master supplies programming level.
// - Every byte in either direction travels least significant bit first.
// - Command F0 streams data bytes from start address to end of memory.
// - After last data byte, CRC of command, address and data in sixteen slots.
// - After closing CRC every read slot returns one until a reset pulse.
// - Read cut short by reset pulse gives no CRC.
// - Command AA streams status bytes to end of eight-byte page, then CRC.
// - First status page CRC covers command, address and bytes through page end.
// - Later status pages clear the CRC and cover that page's bytes only.
// - Programmed byte reads back as AND of all bytes ever programmed there.
`timescale 1ns/1ps
module aom_mem_top import aom_pkg::*; #(
    parameter int PAGES = DATA_PAGES,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Slots from the line front end, same clock
    input wire logic wr_slot_i,
    input wire logic wr_bit_i,
    input wire logic rd_slot_i,
    input wire logic line_reset_i,
    // Programming level detect, asynchronous
    input wire logic prog_level_i,
    // Results
    output logic tx_bit_o,
    output logic prog_done_o,
    output logic prog_refused_o
);
    localparam int DATA_BYTES = PAGES * PAGE_BYTES;
    localparam int DADDR_W = $clog2(DATA_BYTES);
    localparam logic [15:0] DATA_LAST = 16'(DATA_BYTES - 1);
    localparam logic [16:0] DATA_END = 17'(DATA_BYTES);

    // Storage, erased to all ones
    logic [7:0] data_mem [DATA_BYTES];
    logic [7:0] stat_mem [STAT_BYTES];

    aom_state_t state;
    aom_state_t next_state;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] scratch;
    logic [6:0] rx_shift;
    logic [2:0] rx_cnt;
    logic crc_sel;
    logic [6:0] tx_shift;
    logic [2:0] tx_cnt;
    logic pv_meta;
    logic pv_sync;
    logic pv_last;

    // Status map decode, used for both reads and writes
    function automatic logic stat_impl(input logic [15:0] a);
        stat_impl = (a < STAT_GAP_BASE) || (a >= STAT_REDIR_BASE && a <= STAT_LAST);
    endfunction

    function automatic logic [8:0] stat_index(input logic [15:0] a);
        if (a < STAT_GAP_BASE) stat_index = a[8:0];
        else stat_index = 9'(STAT_LOW_BYTES) + {1'b0, a[7:0]};
    endfunction

    function automatic logic data_impl(input logic [15:0] a);
        data_impl = {1'b0, a} < DATA_END;
    endfunction

    // Receive side, least significant bit arrives first
    wire rx_done = wr_slot_i && (rx_cnt == 3'h7);
    wire [7:0] rx_byte = {wr_bit_i, rx_shift};
    wire rx_state = (state == AOM_CMD) || (state == AOM_ADR_LO) ||
                    (state == AOM_ADR_HI) || (state == AOM_WR_DATA);
    wire rx_take = rx_done && rx_state;
    wire [15:0] new_addr = {rx_byte, addr[7:0]};
    wire [15:0] addr_inc = addr + 16'h0001;

    // Command class
    wire is_stat = (cmd == CMD_READ_STAT) || (cmd == CMD_WRITE_STAT);
    wire data_ok = data_impl(addr);
    wire stat_ok = stat_impl(addr);
    wire [DADDR_W-1:0] data_idx = addr[DADDR_W-1:0];
    wire [8:0] stat_idx = stat_index(addr);
    wire [7:0] stat_rd = stat_ok ? stat_mem[stat_idx] : UNIMPL_BYTE;
    wire [7:0] data_rd = data_ok ? data_mem[data_idx] : ERASED_BYTE;
    wire [7:0] rd_byte = is_stat ? stat_rd : data_rd;

    // Protection lookup
    wire [7:0] page = addr[12:5];
    wire [7:0] wp_byte = stat_mem[STAT_WP_BASE[8:0] + {4'h0, page[7:3]}];
    wire wp_open = wp_byte[page[2:0]];
    wire [7:0] rp_byte = stat_mem[STAT_RP_BASE[8:0] + {4'h0, addr[7:3]}];
    wire rp_open = rp_byte[addr[2:0]];
    wire is_redir = (addr[15:8] == STAT_REDIR_BASE[15:8]);
    // Flags and redirection bytes take part in no decision here
    wire stat_wr_ok = stat_ok && (!is_redir || rp_open);
    wire prog_allowed = is_stat ? stat_wr_ok : (data_ok && wp_open);

    // Programming level, two flops before use
    wire prog_rise = pv_sync && !pv_last;
    wire prog_fire = (state == AOM_WR_PROG) && prog_rise;
    wire prog_write = prog_fire && prog_allowed;

    // Producer into the output FIFO
    logic [15:0] crc;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out;
    wire crc_state = (state == AOM_RD_CRC) || (state == AOM_WR_CRC);
    wire push_valid = (state == AOM_FETCH) || crc_state || (state == AOM_WR_VER);
    wire [7:0] crc_byte_out = crc_sel ? crc[15:8] : crc[7:0];
    wire [7:0] push_data = crc_state ? crc_byte_out : rd_byte;
    wire push_fire = push_valid && fifo_in_ready && !line_reset_i;
    wire fetch_last = is_stat ? (addr[2:0] == STAT_PAGE_LAST) : (addr == DATA_LAST);
    wire crc_sent = (state == AOM_RD_CRC) && push_fire && crc_sel;
    wire stat_more = is_stat && (addr <= STAT_LAST);
    wire page_restart = crc_sent && stat_more;
    wire ver_fire = (state == AOM_WR_VER) && push_fire;

    // CRC controls
    wire crc_init = (rx_take && state == AOM_CMD) || page_restart || ver_fire;
    wire [15:0] crc_init_val = ver_fire ? addr_inc : CRC_CLEAR;
    wire crc_upd = rx_take || ((state == AOM_FETCH) && push_fire);
    wire [7:0] crc_in = rx_take ? rx_byte : rd_byte;

    aom_crc16 u_crc (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .init_i(crc_init || line_reset_i),
        .init_val_i(line_reset_i ? CRC_CLEAR : crc_init_val),
        .upd_i(crc_upd && !line_reset_i),
        .byte_i(crc_in),
        .crc_o(crc)
    );

    // Drain side: one byte leaves only when a read slot needs a fresh byte
    wire fifo_out_ready = rd_slot_i && (tx_cnt == 3'h0) && !line_reset_i;

    aom_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .flush_i(line_reset_i),
        .in_valid_i(push_valid && !line_reset_i),
        .in_data_i(push_data),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out),
        .out_ready_i(fifo_out_ready)
    );

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            AOM_CMD: begin
                if (rx_take) next_state = AOM_ADR_LO;
            end
            AOM_ADR_LO: begin
                if (rx_take) next_state = AOM_ADR_HI;
            end
            AOM_ADR_HI: begin
                if (rx_take) begin
                    case (cmd)
                        CMD_READ_MEM: begin
                            next_state = data_impl(new_addr) ? AOM_FETCH : AOM_RD_CRC;
                        end
                        CMD_READ_STAT: next_state = AOM_FETCH;
                        CMD_WRITE_MEM, CMD_WRITE_STAT: next_state = AOM_WR_DATA;
                        default: next_state = AOM_DONE;
                    endcase
                end
            end
            AOM_FETCH: begin
                if (push_fire && fetch_last) next_state = AOM_RD_CRC;
            end
            AOM_RD_CRC: begin
                if (crc_sent) next_state = stat_more ? AOM_FETCH : AOM_DONE;
            end
            AOM_WR_DATA: begin
                if (rx_take) next_state = AOM_WR_CRC;
            end
            AOM_WR_CRC: begin
                if (push_fire && crc_sel) next_state = AOM_WR_PROG;
            end
            AOM_WR_PROG: begin
                if (prog_fire) next_state = AOM_WR_VER;
            end
            AOM_WR_VER: begin
                if (ver_fire) next_state = AOM_WR_DATA;
            end
            AOM_DONE: next_state = AOM_DONE;
            default: next_state = AOM_CMD;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= AOM_CMD;
        end else if (line_reset_i) begin
            state <= AOM_CMD;
        end else begin
            state <= next_state;
        end
    end

    // Command, address and scratchpad
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd <= 8'h00;
            addr <= 16'h0000;
            scratch <= ERASED_BYTE;
        end else if (line_reset_i) begin
            cmd <= 8'h00;
            scratch <= ERASED_BYTE;
        end else if (rx_take) begin
            case (state)
                AOM_CMD: cmd <= rx_byte;
                AOM_ADR_LO: addr[7:0] <= rx_byte;
                AOM_ADR_HI: addr[15:8] <= rx_byte;
                AOM_WR_DATA: scratch <= rx_byte;
                default: scratch <= scratch;
            endcase
        end else if ((state == AOM_FETCH && push_fire) || ver_fire) begin
            addr <= addr_inc;
        end
    end

    // Bit assembly and CRC byte select
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_shift <= 7'h00;
            rx_cnt <= 3'h0;
            crc_sel <= 1'b0;
        end else if (line_reset_i) begin
            rx_cnt <= 3'h0;
            crc_sel <= 1'b0;
        end else begin
            if (wr_slot_i) begin
                rx_shift <= rx_byte[7:1];
                rx_cnt <= rx_cnt + 3'h1;
            end
            if (crc_state && push_fire) crc_sel <= !crc_sel;
        end
    end

    // Programming level synchroniser
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pv_meta <= 1'b0;
            pv_sync <= 1'b0;
            pv_last <= 1'b0;
        end else begin
            pv_meta <= prog_level_i;
            pv_sync <= pv_meta;
            pv_last <= pv_sync;
        end
    end

    // Storage; a write can only clear bits, so the result is a running AND
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DATA_BYTES; i++) data_mem[i] <= ERASED_BYTE;
            for (int j = 0; j < STAT_BYTES; j++) stat_mem[j] <= ERASED_BYTE;
        end else if (prog_write && !line_reset_i) begin
            if (is_stat) stat_mem[stat_idx] <= stat_rd & scratch;
            else data_mem[data_idx] <= data_rd & scratch;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_done_o <= 1'b0;
            prog_refused_o <= 1'b0;
        end else begin
            prog_done_o <= prog_write && !line_reset_i;
            prog_refused_o <= prog_fire && !prog_allowed && !line_reset_i;
        end
    end

    // Serialiser; an empty buffer answers with ones, which covers the tail after the CRC
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_bit_o <= 1'b1;
            tx_shift <= 7'h7F;
            tx_cnt <= 3'h0;
        end else if (line_reset_i) begin
            tx_bit_o <= 1'b1;
            tx_cnt <= 3'h0;
        end else if (rd_slot_i) begin
            if (tx_cnt != 3'h0) begin
                tx_bit_o <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[6:1]};
                tx_cnt <= tx_cnt - 3'h1;
            end else if (fifo_out_valid) begin
                tx_bit_o <= fifo_out[0];
                tx_shift <= fifo_out[7:1];
                tx_cnt <= 3'h7;
            end else begin
                tx_bit_o <= 1'b1;
            end
        end
    end
endmodule

// ### shared/aom_pkg.sv
// Constants, address map and state encoding for the add-only memory block
package aom_pkg;

    // Memory function command bytes
    localparam logic [7:0] CMD_READ_MEM = 8'hF0;
    localparam logic [7:0] CMD_READ_STAT = 8'hAA;
    localparam logic [7:0] CMD_WRITE_MEM = 8'h3C;
    localparam logic [7:0] CMD_WRITE_STAT = 8'h5A;

    // Data memory and status page geometry
    localparam int DATA_PAGES = 256;
    localparam int PAGE_BYTES = 32;
    localparam int STAT_PAGE_BYTES = 8;
    localparam logic [2:0] STAT_PAGE_LAST = 3'h7;

    // Status memory map
    localparam logic [15:0] STAT_WP_BASE = 16'h0000;
    localparam logic [15:0] STAT_RP_BASE = 16'h0020;
    localparam logic [15:0] STAT_FLAG_BASE = 16'h0040;
    localparam logic [15:0] STAT_GAP_BASE = 16'h0060;
    localparam logic [15:0] STAT_REDIR_BASE = 16'h0100;
    localparam logic [15:0] STAT_LAST = 16'h01FF;
    localparam int STAT_LOW_BYTES = 96;
    localparam int STAT_BYTES = 352;

    // Values after reset and for unimplemented locations
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] UNIMPL_BYTE = 8'hFF;

    // CRC generator, reflected form, shifted least significant bit first
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_CLEAR = 16'h0000;

    // Output buffer
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [3:0] {
        AOM_CMD = 4'h0,
        AOM_ADR_LO = 4'h1,
        AOM_ADR_HI = 4'h3,
        AOM_FETCH = 4'h2,
        AOM_RD_CRC = 4'h6,
        AOM_DONE = 4'h7,
        AOM_WR_DATA = 4'hB,
        AOM_WR_CRC = 4'hF,
        AOM_WR_PROG = 4'hE,
        AOM_WR_VER = 4'hA
    } aom_state_t;

endpackage

// ### sim/addonly_eprom_memory_commands_tb.sv
// Self-checking bench for the add-only memory command block
`timescale 1ns/1ps
module addonly_eprom_memory_commands_tb import aom_pkg::*; ;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_slot;
    logic wr_bit;
    logic rd_slot;
    logic line_reset;
    logic prog_level;
    logic tx_bit;
    logic prog_done;
    logic prog_refused;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] dmem [logic [15:0]];
    logic [7:0] smem [logic [15:0]];

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    aom_mem_top aom_mem_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .wr_slot_i(wr_slot), .wr_bit_i(wr_bit), .rd_slot_i(rd_slot),
        .line_reset_i(line_reset), .prog_level_i(prog_level), .tx_bit_o(tx_bit),
        .prog_done_o(prog_done), .prog_refused_o(prog_refused));
    // Programming level held 40 cycles, not the full pulse, to keep the run short
    aom_master_model #(.PROG_HOLD(40)) aom_master_model_inst (.clock_i(clock_i),
        .wr_slot_o(wr_slot), .wr_bit_o(wr_bit), .rd_slot_o(rd_slot),
        .line_reset_o(line_reset), .prog_level_o(prog_level), .tx_bit_i(tx_bit),
        .prog_done_i(prog_done), .prog_refused_i(prog_refused));

    function automatic logic [7:0] dget(input logic [15:0] a);
        return dmem.exists(a) ? dmem[a] : ERASED_BYTE;
    endfunction

    function automatic logic [7:0] sget(input logic [15:0] a);
        if (a >= 16'h0200 || (a >= STAT_GAP_BASE && a < STAT_REDIR_BASE)) return UNIMPL_BYTE;
        return smem.exists(a) ? smem[a] : ERASED_BYTE;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic is_blocked(input logic [7:0] cmd, input logic [15:0] a);
        logic [7:0] s;
        if (cmd == CMD_WRITE_MEM) begin
            s = sget({11'h000, a[12:8]});
            return !s[a[7:5]];
        end
        if (sget(a) === UNIMPL_BYTE && a >= STAT_GAP_BASE && a < STAT_REDIR_BASE) return 1'b1;
        if (a >= 16'h0200) return 1'b1;
        if (a < STAT_REDIR_BASE) return 1'b0;
        s = sget(STAT_RP_BASE + {11'h000, a[7:3]});
        return !s[a[2:0]];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic get_crc(output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        aom_master_model_inst.get_byte(lo);
        aom_master_model_inst.get_byte(hi);
        c = {hi, lo};
    endtask

    task automatic wr_op(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d);
        logic [15:0] c;
        logic [15:0] got;
        logic [7:0] v;
        logic [7:0] e;
        logic blk;
        logic dn;
        logic rf;
        blk = is_blocked(cmd, a);
        e = (cmd == CMD_WRITE_MEM) ? dget(a) : sget(a);
        if (!blk) e = e & d;
        aom_master_model_inst.start(cmd, a);
        aom_master_model_inst.send_byte(d);
        c = crc_byte(crc_byte(crc_byte(crc_byte(CRC_CLEAR, cmd), a[7:0]), a[15:8]), d);
        get_crc(got);
        check(got, c);
        if (got === c) begin
            aom_master_model_inst.apply_prog(dn, rf);
            check({14'h0000, dn, rf}, {14'h0000, !blk, blk});
            if (!dn && !rf) conclude();
            if (cmd == CMD_WRITE_MEM) dmem[a] = e;
            else smem[a] = e;
            aom_master_model_inst.get_byte(v);
            check({8'h00, v}, {8'h00, e});
        end
        aom_master_model_inst.pulse_reset();
    endtask

    task automatic rd_stat(input logic [15:0] a, input int pages);
        logic [15:0] c;
        logic [15:0] got;
        logic [7:0] v;
        c = crc_byte(crc_byte(crc_byte(CRC_CLEAR, CMD_READ_STAT), a[7:0]), a[15:8]);
        aom_master_model_inst.start(CMD_READ_STAT, a);
        while (pages > 0) begin
            aom_master_model_inst.get_byte(v);
            check({8'h00, v}, {8'h00, sget(a)});
            c = crc_byte(c, sget(a));
            if (a[2:0] == STAT_PAGE_LAST) begin
                get_crc(got);
                check(got, c);
                c = CRC_CLEAR;
                pages--;
            end
            a++;
        end
        aom_master_model_inst.pulse_reset();
    endtask

    task automatic rd_mem(input logic [15:0] a);
        logic [15:0] c;
        logic [15:0] got;
        logic [7:0] v;
        c = crc_byte(crc_byte(crc_byte(CRC_CLEAR, CMD_READ_MEM), a[7:0]), a[15:8]);
        aom_master_model_inst.start(CMD_READ_MEM, a);
        for (int i = a; i < DATA_PAGES * PAGE_BYTES; i++) begin
            aom_master_model_inst.get_byte(v);
            check({8'h00, v}, {8'h00, dget(i[15:0])});
            c = crc_byte(c, dget(i[15:0]));
        end
        get_crc(got);
        check(got, c);
        aom_master_model_inst.get_byte(v);
        check({8'h00, v}, 16'h00FF);
        aom_master_model_inst.pulse_reset();
    endtask

    initial begin
        logic [15:0] a;
        logic [7:0] v;
        void'($urandom(65521));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        aom_master_model_inst.get_byte(v);
        check({8'h00, v}, 16'h00FF);
        for (int n = 0; n < 3; n++) begin
            a = {3'h0, 13'($urandom)};
            wr_op(CMD_WRITE_MEM, a, 8'($urandom));
            wr_op(CMD_WRITE_MEM, a, 8'($urandom));
        end
        $display("test data_write done");
        wr_op(CMD_WRITE_STAT, {11'h000, a[12:8]}, ~(8'h01 << a[7:5]));
        wr_op(CMD_WRITE_MEM, a, 8'h00);
        wr_op(CMD_WRITE_STAT, STAT_REDIR_BASE + {8'h00, a[12:5]}, 8'hFD);
        wr_op(CMD_WRITE_STAT, STAT_RP_BASE + {11'h000, a[12:8]}, ~(8'h01 << a[7:5]));
        wr_op(CMD_WRITE_STAT, STAT_REDIR_BASE + {8'h00, a[12:5]}, 8'h00);
        wr_op(CMD_WRITE_STAT, STAT_FLAG_BASE + {11'h000, a[12:8]}, 8'h7E);
        wr_op(CMD_WRITE_MEM, a ^ 16'h0020, 8'h5A);
        wr_op(CMD_WRITE_STAT, 16'h0070, 8'h00);
        wr_op(CMD_WRITE_STAT, 16'h0200, 8'h00);
        $display("test protect done");
        rd_stat({9'h000, 7'($urandom_range(95))}, 2);
        rd_stat(16'h005D, 2);
        rd_stat(STAT_REDIR_BASE + {8'h00, a[12:5]}, 1);
        $display("test status_read done");
        wr_op(CMD_WRITE_MEM, 16'h1FFF, 8'($urandom));
        rd_mem(16'h1FE0 + {11'h000, 5'($urandom)});
        $display("test memory_read done");
        aom_master_model_inst.start(CMD_READ_MEM, a - 16'h1);
        aom_master_model_inst.get_byte(v);
        aom_master_model_inst.pulse_reset();
        aom_master_model_inst.get_byte(v);
        check({8'h00, v}, 16'h00FF);
        rd_stat(16'h0000, 1);
        $display("test abort done");
        conclude();
    end
endmodule

// ### sim/aom_master_model.sv
// Behavioural single-wire bus master driving the slot ports
`timescale 1ns/1ps
module aom_master_model #(
    parameter int PROG_HOLD = 24000
) (
    // Clock
    input wire logic clock_i,
    // Slot drive
    output logic wr_slot_o,
    output logic wr_bit_o,
    output logic rd_slot_o,
    output logic line_reset_o,
    output logic prog_level_o,
    // Answers
    input wire logic tx_bit_i,
    input wire logic prog_done_i,
    input wire logic prog_refused_i
);
    initial begin
        wr_slot_o = 1'b0;
        wr_bit_o = 1'b1;
        rd_slot_o = 1'b0;
        line_reset_o = 1'b0;
        prog_level_o = 1'b0;
    end

    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            wr_slot_o <= 1'b1;
            wr_bit_o <= b[i];
        end
        @(posedge clock_i);
        wr_slot_o <= 1'b0;
        // Released bit line must not keep the last bit
        wr_bit_o <= ~b[7];
        repeat (3) @(posedge clock_i);
    endtask

    task automatic start(input logic [7:0] cmd, input logic [15:0] a);
        send_byte(cmd);
        send_byte(a[7:0]);
        send_byte(a[15:8]);
    endtask

    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            rd_slot_o <= 1'b1;
            @(posedge clock_i);
            rd_slot_o <= 1'b0;
            #1 b[i] = tx_bit_i;
        end
    endtask

    task automatic pulse_reset();
        @(posedge clock_i);
        line_reset_o <= 1'b1;
        @(posedge clock_i);
        line_reset_o <= 1'b0;
    endtask

    task automatic apply_prog(output logic done, output logic refused);
        done = 1'b0;
        refused = 1'b0;
        @(posedge clock_i);
        prog_level_o <= 1'b1;
        repeat (PROG_HOLD) begin
            @(posedge clock_i);
            #1;
            done = done | prog_done_i;
            refused = refused | prog_refused_i;
        end
        @(posedge clock_i);
        prog_level_o <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
endmodule

// ### sim/aom_mem_props.sv
// Port assertions for the add-only memory command block
`timescale 1ns/1ps
module aom_mem_props (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Slots and programming level
    input wire logic wr_slot_i,
    input wire logic wr_bit_i,
    input wire logic rd_slot_i,
    input wire logic line_reset_i,
    input wire logic prog_level_i,
    // Results
    input wire logic tx_bit_o,
    input wire logic prog_done_o,
    input wire logic prog_refused_o
);
    // Write slots since the last line reset, saturating past one full write
    logic [5:0] wr_count;
    wire logic cnt_sat;
    assign cnt_sat = (wr_count == 6'h28);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) wr_count <= 6'h00;
        else if (line_reset_i) wr_count <= 6'h00;
        else if (wr_slot_i && !cnt_sat) wr_count <= wr_count + 6'h01;
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    tx_holds_a: assert property (!rd_slot_i && !line_reset_i |=> $stable(tx_bit_o))
        else $error("tx bit moved without a read slot");
    abort_idle_a: assert property (line_reset_i |=> tx_bit_o && !prog_done_o)
        else $error("line reset did not return to idle");
    early_read_a: assert property (rd_slot_i && wr_count < 6'h18 |=> tx_bit_o)
        else $error("data answered before a full command");
    done_count_a: assert property (prog_done_o |-> wr_count >= 6'h20)
        else $error("programmed before data byte was received");
    done_pulse_a: assert property (prog_done_o |=> !prog_done_o)
        else $error("programming done longer than one cycle");
    refuse_pulse_a: assert property (prog_refused_o |=> !prog_refused_o)
        else $error("refusal longer than one cycle");
    outcome_excl_a: assert property (!(prog_done_o && prog_refused_o))
        else $error("done and refused together");
    level_cause_a: assert property (prog_done_o || prog_refused_o |-> $past(prog_level_i, 2))
        else $error("programming outcome without programming level");
endmodule

bind aom_mem_top aom_mem_props aom_mem_props_inst (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_slot_i(wr_slot_i),
    .wr_bit_i(wr_bit_i),
    .rd_slot_i(rd_slot_i),
    .line_reset_i(line_reset_i),
    .prog_level_i(prog_level_i),
    .tx_bit_o(tx_bit_o),
    .prog_done_o(prog_done_o),
    .prog_refused_o(prog_refused_o)
);
